//--- verilog/pbk_break_unit.sv
// two channel program break unit with register file
// How it works
// - two identical independent break channels
// - 24-bit break address, zero after reset
// - address top byte reserved, writes ignored
// - mask code drops 0-4, 8, 12, 16 bits
// - condition: fetch, read, write, read/write
// - master select allows transfer controller cycles
// - match sets channel condition flag
// - flag clears on zero write after read
// - request forwarded only when enable set
// - fetch break before matched instruction executes
// - data break after accessing instruction completes
// - module stop halts all matching
// - starts stopped, registers locked until released
// - both channels share one break request
// - flag left set keeps requesting
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pbk_break_unit
    import pbk_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // async reset, low
    input wire logic ce_i, // clock enable
    input wire logic [RA_W-1:0] reg_addr_i, // register byte addr
    input wire logic [31:0] reg_wdata_i, // write data
    input wire logic reg_wr_i, // write strobe
    input wire logic reg_rd_i, // read strobe
    output logic [31:0] reg_rdata_o, // read data, next cycle
    input wire logic bus_valid_i, // bus cycle present
    input wire logic [BA_W-1:0] bus_addr_i, // bus address
    input wire logic [1:0] bus_kind_i, // fetch/read/write
    input wire logic bus_xfer_ctl_i, // transfer ctl master
    input wire logic insn_end_i, // instruction completes
    output logic break_irq_o, // shared break request
    output logic break_fetch_o, // break before execute
    output logic break_data_o, // break after instruction
    output logic irq_o, // masked status interrupt
    output logic mod_stop_o // unit is in module stop
);
    // --------------------------------------------------
    // state
    // --------------------------------------------------
    typedef struct packed {
        logic [NCH-1:0][23:0] baddr; // break addresses
        logic [NCH-1:0][7:0] ctrl; // control registers
        logic [NCH-1:0] armed; // flag read as one
        logic [NCH-1:0] pend; // data break waiting
        logic [NCH-1:0] stat; // sticky event bits
        logic [NCH-1:0] imask; // event enables
        logic stop; // module stop
        logic [31:0] rdata; // read data
        logic brk_irq; // break request
        logic brk_fetch; // fetch break pulse
        logic brk_data; // data break pulse
        logic irq; // status interrupt
    } pbk_state_t;
    localparam pbk_state_t ST_RST = '{
        baddr: {NCH{RST_BRK_ADDR}},
        ctrl: {NCH{RST_CTRL}},
        armed: '0,
        pend: '0,
        stat: '0,
        imask: {NCH{RST_IRQ_MASK}},
        stop: RST_MOD_STOP,
        rdata: '0,
        brk_irq: 1'b0,
        brk_fetch: 1'b0,
        brk_data: 1'b0,
        irq: 1'b0
    };
    pbk_state_t st; // registered state
    pbk_state_t next_st; // next state
    logic [NCH-1:0] hit_fetch; // fetch match per channel
    logic [NCH-1:0] hit_data; // data match per channel
    logic [NCH-1:0] ev_set; // flag set events
    logic [NCH-1:0] pend_now; // pending incl. this cycle
    logic [NCH-1:0] req_now; // flag and enable
    logic [NCH-1:0] sel_addr; // address reg selected
    logic [NCH-1:0] sel_ctrl; // control reg selected
    logic open_acc; // registers accessible
    // offset of a channel register
    function automatic logic [7:0] ch_ofs(logic [7:0] base,
                                          int ch);
        return base + 8'(ch * 4);
    endfunction
    // --------------------------------------------------
    // channels
    // --------------------------------------------------
    // one comparator per channel
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        pbk_chan_if cif ();
        assign cif.brk_addr = st.baddr[g];
        assign cif.mask_code = st.ctrl[g][FLD_MASK_LSB +: 3];
        assign cif.cond_sel = st.ctrl[g][FLD_COND_LSB +: 2];
        assign cif.master_sel = st.ctrl[g][FLD_MASTER_SEL];
        assign cif.run = !st.stop;
        assign cif.bus_valid = bus_valid_i;
        assign cif.bus_addr = bus_addr_i;
        assign cif.bus_kind = bus_kind_i;
        assign cif.bus_xfer_ctl = bus_xfer_ctl_i;
        assign hit_fetch[g] = cif.hit_fetch;
        assign hit_data[g] = cif.hit_data;
        pbk_chan_cmp u_cmp (
            .clk_sys_i (clk_sys_i),
            .rst_n_i (rst_n_i),
            .ce_i (ce_i),
            .ch_if (cif.cmp)
        );
    end
    // --------------------------------------------------
    // next state
    // --------------------------------------------------
    always_comb
    begin
        next_st = st;
        ev_set = '0;
        pend_now = '0;
        req_now = '0;
        sel_addr = '0;
        sel_ctrl = '0;
        next_st.rdata = 32'h0;
        next_st.brk_fetch = 1'b0;
        next_st.brk_data = 1'b0;
        open_acc = !st.stop;
        for (int c = 0; c < NCH; c++)
        begin
            sel_addr[c] = reg_addr_i == ch_ofs(OFS_ADDR_A, c);
            sel_ctrl[c] = reg_addr_i == ch_ofs(OFS_CTRL_A, c);
            // hold data hit to insn end
            pend_now[c] = (st.pend[c] | hit_data[c]) & !st.stop;
            next_st.pend[c] = pend_now[c] & !insn_end_i;
            ev_set[c] = hit_fetch[c] | (pend_now[c] & insn_end_i);
            if (hit_fetch[c] && st.ctrl[c][FLD_IRQ_EN])
            begin
                next_st.brk_fetch = 1'b1;
            end
            if (pend_now[c] && insn_end_i
                && st.ctrl[c][FLD_IRQ_EN])
            begin
                next_st.brk_data = 1'b1;
            end
        end
        // register reads
        if (reg_rd_i)
        begin
            if (reg_addr_i == OFS_MOD_STOP)
            begin
                next_st.rdata = {31'h0, st.stop};
            end
            else if (open_acc && reg_addr_i == OFS_IRQ_STAT)
            begin
                next_st.rdata = {30'h0, st.stat};
            end
            else if (open_acc && reg_addr_i == OFS_IRQ_MASK)
            begin
                next_st.rdata = {30'h0, st.imask};
            end
            for (int c = 0; c < NCH; c++)
            begin
                if (open_acc && sel_addr[c])
                begin
                    next_st.rdata = {8'h00, st.baddr[c]};
                end
                if (open_acc && sel_ctrl[c])
                begin
                    next_st.rdata = {24'h0, st.ctrl[c]};
                    if (st.ctrl[c][FLD_MATCH_FLAG])
                    begin
                        next_st.armed[c] = 1'b1;
                    end
                end
            end
        end
        // register writes
        if (reg_wr_i)
        begin
            // stop control is always reachable
            if (reg_addr_i == OFS_MOD_STOP)
            begin
                next_st.stop = reg_wdata_i[0];
            end
            else if (open_acc && reg_addr_i == OFS_IRQ_STAT)
            begin
                next_st.stat = st.stat & ~reg_wdata_i[NCH-1:0];
            end
            else if (open_acc && reg_addr_i == OFS_IRQ_MASK)
            begin
                next_st.imask = reg_wdata_i[NCH-1:0];
            end
            for (int c = 0; c < NCH; c++)
            begin
                if (open_acc && sel_addr[c])
                begin
                    next_st.baddr[c] = reg_wdata_i[23:0];
                end
                if (open_acc && sel_ctrl[c])
                begin
                    next_st.ctrl[c][6:0] = reg_wdata_i[6:0];
                    if (!reg_wdata_i[FLD_MATCH_FLAG] && st.armed[c])
                    begin
                        next_st.ctrl[c][FLD_MATCH_FLAG] = 1'b0;
                    end
                    next_st.armed[c] = 1'b0;
                end
            end
        end
        // event set wins over clear
        for (int c = 0; c < NCH; c++)
        begin
            if (ev_set[c])
            begin
                next_st.ctrl[c][FLD_MATCH_FLAG] = 1'b1;
                next_st.stat[c] = 1'b1;
            end
            req_now[c] = next_st.ctrl[c][FLD_MATCH_FLAG]
                & next_st.ctrl[c][FLD_IRQ_EN];
        end
        next_st.brk_irq = |req_now;
        next_st.irq = |(next_st.stat & next_st.imask);
    end
    // state register
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i) st <= ST_RST;
        else if (ce_i) st <= next_st;
    end
    // --------------------------------------------------
    // outputs
    // --------------------------------------------------
    assign reg_rdata_o = st.rdata;
    assign break_irq_o = st.brk_irq;
    assign break_fetch_o = st.brk_fetch;
    assign break_data_o = st.brk_data;
    assign irq_o = st.irq;
    assign mod_stop_o = st.stop;
    // --------------------------------------------------
    // checks
    // --------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_read_one;
        ce_i && reg_rd_i && sel_ctrl[0] && open_acc
            && st.ctrl[0][FLD_MATCH_FLAG];
    endsequence
    sequence s_zero_write;
        ce_i && reg_wr_i && sel_ctrl[0] && open_acc
            && !reg_wdata_i[FLD_MATCH_FLAG] && !ev_set[0];
    endsequence
    property p_flag_set;
        ce_i && ev_set[1] |=> st.ctrl[1][FLD_MATCH_FLAG];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("match did not set flag");
    property p_clear_seq;
        s_read_one ##1 (!ce_i || !reg_wr_i) ##1 s_zero_write
            |=> !st.ctrl[0][FLD_MATCH_FLAG];
    endproperty
    a_clear_seq: assert property (p_clear_seq)
        else $error("flag not cleared after read");
    property p_clear_cause;
        ce_i && st.ctrl[0][FLD_MATCH_FLAG]
            ##1 !st.ctrl[0][FLD_MATCH_FLAG]
            |-> $past(st.armed[0]) && $past(reg_wr_i);
    endproperty
    a_clear_cause: assert property (p_clear_cause)
        else $error("flag cleared without read");
    property p_enable_gate;
        ce_i && !next_st.ctrl[0][FLD_IRQ_EN]
            && !next_st.ctrl[1][FLD_IRQ_EN] |=> !break_irq_o;
    endproperty
    a_enable_gate: assert property (p_enable_gate)
        else $error("request while disabled");
    property p_shared_req;
        ce_i && st.ctrl[1][FLD_MATCH_FLAG] && st.ctrl[1][FLD_IRQ_EN]
            && !(reg_wr_i && sel_ctrl[1]) |=> break_irq_o;
    endproperty
    a_shared_req: assert property (p_shared_req)
        else $error("flag set but no request");
    property p_fetch_now;
        ce_i && hit_fetch[0] && st.ctrl[0][FLD_IRQ_EN]
            |=> break_fetch_o;
    endproperty
    a_fetch_now: assert property (p_fetch_now)
        else $error("fetch break missed");
    // data hit on channel b, two idle cycles, then insn end
    sequence s_data_hit;
        ce_i && !st.stop && hit_data[1] && !insn_end_i
            && st.ctrl[1][FLD_IRQ_EN];
    endsequence
    property p_data_wait;
        s_data_hit ##1 ((!ce_i || !insn_end_i) && !st.stop)[*2]
            ##1 (ce_i && insn_end_i && !st.stop
            && st.ctrl[1][FLD_IRQ_EN])
            |=> break_data_o && st.ctrl[1][FLD_MATCH_FLAG];
    endproperty
    a_data_wait: assert property (p_data_wait)
        else $error("data break not at insn end");
    property p_stop_quiet;
        st.stop && $past(st.stop) && $past(st.stop, 2) |-> ev_set == '0;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("match during module stop");
    property p_stop_lock;
        ce_i && st.stop && reg_wr_i && sel_addr[0] |=> $stable(st.baddr[0]);
    endproperty
    a_stop_lock: assert property (p_stop_lock)
        else $error("write took effect while stopped");
    property p_top_byte;
        ce_i && reg_rd_i && sel_addr[1] |=> reg_rdata_o[31:24] == 8'h00;
    endproperty
    a_top_byte: assert property (p_top_byte)
        else $error("reserved byte not zero");
endmodule // pbk_break_unit
`default_nettype wire

//--- verilog/pbk_pkg.sv
// constants shared by the program break unit files
`default_nettype none
package pbk_pkg;
    // --------------------------------------------------
    // geometry
    // --------------------------------------------------
    localparam int NCH = 2; // break channels
    localparam int BA_W = 24; // break address width
    localparam int RA_W = 8; // register address width
    // --------------------------------------------------
    // register byte offsets
    // --------------------------------------------------
    localparam logic [7:0] OFS_ADDR_A = 8'h00;
    localparam logic [7:0] OFS_ADDR_B = 8'h04;
    localparam logic [7:0] OFS_CTRL_A = 8'h08;
    localparam logic [7:0] OFS_CTRL_B = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
    localparam logic [7:0] OFS_MOD_STOP = 8'h18;
    // --------------------------------------------------
    // control register fields
    // --------------------------------------------------
    localparam int FLD_MATCH_FLAG = 7; // condition match flag
    localparam int FLD_MASTER_SEL = 6; // 1: cpu or transfer ctl
    localparam int FLD_MASK_LSB = 3; // 3-bit address mask code
    localparam int FLD_COND_LSB = 1; // 2-bit condition select
    localparam int FLD_IRQ_EN = 0; // break interrupt enable
    // --------------------------------------------------
    // reset values
    // --------------------------------------------------
    localparam logic [23:0] RST_BRK_ADDR = 24'h000000;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic RST_IRQ_MASK = 1'b0;
    localparam logic RST_MOD_STOP = 1'b1;
    // --------------------------------------------------
    // condition and bus cycle codes
    // --------------------------------------------------
    localparam logic [1:0] COND_FETCH = 2'h0;
    localparam logic [1:0] COND_READ = 2'h1;
    localparam logic [1:0] COND_WRITE = 2'h2;
    localparam logic [1:0] COND_RDWR = 2'h3;
    localparam logic [1:0] KIND_FETCH = 2'h0;
    localparam logic [1:0] KIND_READ = 2'h1;
    localparam logic [1:0] KIND_WRITE = 2'h2;
endpackage
`default_nettype wire

//--- verilog/pbk_chan_if.sv
// per-channel link between register file and comparator
`timescale 1ns/1ps
`default_nettype none
interface pbk_chan_if;
    logic [23:0] brk_addr; // break address
    logic [2:0] mask_code; // low bit mask code
    logic [1:0] cond_sel; // cycle type select
    logic master_sel; // allow transfer ctl cycles
    logic run; // unit not stopped
    logic bus_valid; // bus cycle present
    logic [23:0] bus_addr; // bus cycle address
    logic [1:0] bus_kind; // fetch, read or write
    logic bus_xfer_ctl; // cycle owned by transfer ctl
    logic hit_fetch; // registered fetch match
    logic hit_data; // registered data match
    modport ctl (
        output brk_addr, mask_code, cond_sel, master_sel, run,
        output bus_valid, bus_addr, bus_kind, bus_xfer_ctl,
        input hit_fetch, hit_data
    );
    modport cmp (
        input brk_addr, mask_code, cond_sel, master_sel, run,
        input bus_valid, bus_addr, bus_kind, bus_xfer_ctl,
        output hit_fetch, hit_data
    );
endinterface
`default_nettype wire

//--- verilog/pbk_chan_cmp.sv
// one break channel address and cycle comparator
`timescale 1ns/1ps
`default_nettype none
module pbk_chan_cmp
    import pbk_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    input wire logic rst_n_i, // async reset, low
    input wire logic ce_i, // clock enable
    pbk_chan_if.cmp ch_if // channel config and bus
);
    // --------------------------------------------------
    // state
    // --------------------------------------------------
    typedef struct packed {
        logic hit_fetch; // fetch matched last cycle
        logic hit_data; // data access matched
    } pbk_cmp_t;
    pbk_cmp_t st; // registered state
    pbk_cmp_t next_st; // next state
    logic [23:0] keep; // compared address bits
    logic base_ok; // address and master agree
    // bits kept for a mask code
    function automatic logic [23:0] keep_of(logic [2:0] code);
        logic [4:0] drop;
        drop = {2'h0, code};
        if (code == 3'h5) drop = 5'h08;
        if (code == 3'h6) drop = 5'h0C;
        if (code == 3'h7) drop = 5'h10;
        return ~((24'h000001 << drop) - 24'h000001);
    endfunction
    // --------------------------------------------------
    // compare
    // --------------------------------------------------
    always_comb
    begin
        next_st = '0;
        keep = keep_of(ch_if.mask_code);
        base_ok = ch_if.bus_valid && ch_if.run
            && (((ch_if.bus_addr ^ ch_if.brk_addr) & keep) == 24'h0)
            && (!ch_if.bus_xfer_ctl || ch_if.master_sel);
        unique case (ch_if.cond_sel)
            COND_FETCH: next_st.hit_fetch = base_ok
                && (ch_if.bus_kind == KIND_FETCH);
            COND_READ: next_st.hit_data = base_ok
                && (ch_if.bus_kind == KIND_READ);
            COND_WRITE: next_st.hit_data = base_ok
                && (ch_if.bus_kind == KIND_WRITE);
            COND_RDWR: next_st.hit_data = base_ok
                && ((ch_if.bus_kind == KIND_READ)
                || (ch_if.bus_kind == KIND_WRITE));
        endcase
    end
    // register the match
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i) st <= '0;
        else if (ce_i) st <= next_st;
    end
    assign ch_if.hit_fetch = st.hit_fetch;
    assign ch_if.hit_data = st.hit_data;
    // --------------------------------------------------
    // checks
    // --------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    property p_master_gate;
        ce_i && ch_if.bus_xfer_ctl && !ch_if.master_sel
            |=> !st.hit_data && !st.hit_fetch;
    endproperty
    a_master_gate: assert property (p_master_gate)
        else $error("transfer ctl cycle matched");
    property p_mask16;
        ce_i && ch_if.bus_valid && ch_if.run
            && ch_if.mask_code == 3'h7
            && ch_if.cond_sel == COND_FETCH
            && ch_if.bus_kind == KIND_FETCH && !ch_if.bus_xfer_ctl
            && ch_if.bus_addr[23:16] == ch_if.brk_addr[23:16]
            |=> st.hit_fetch;
    endproperty
    a_mask16: assert property (p_mask16)
        else $error("masked fetch did not match");
    property p_kind_sel;
        ce_i && ch_if.cond_sel == COND_WRITE
            && ch_if.bus_kind != KIND_WRITE |=> !st.hit_data;
    endproperty
    a_kind_sel: assert property (p_kind_sel)
        else $error("wrong cycle type matched");
endmodule // pbk_chan_cmp
`default_nettype wire

//--- sim/pbk_cpu_model.sv
// cpu bus stand-in that issues monitored bus cycles
`timescale 1ns/1ps
`default_nettype none
module pbk_cpu_model
    import pbk_pkg::*;
(
    input wire logic clk_sys_i, // system clock
    output logic valid_o, // bus cycle present
    output logic [BA_W-1:0] addr_o, // bus address
    output logic [1:0] kind_o, // cycle kind
    output logic xfer_o, // transfer ctl owns cycle
    output logic insn_end_o // instruction completes
);
    initial
    begin
        valid_o = 1'b0;
        addr_o = 24'h000000;
        kind_o = 2'h3;
        xfer_o = 1'b0;
        insn_end_o = 1'b0;
    end
    // one bus cycle; released lines show inverted values
    task automatic cyc(input logic [23:0] a, input logic [1:0] k,
                       input logic x);
        @(posedge clk_sys_i);
        valid_o <= 1'b1;
        addr_o <= a;
        kind_o <= k;
        xfer_o <= x;
        @(posedge clk_sys_i);
        valid_o <= 1'b0;
        addr_o <= ~a;
        kind_o <= ~k;
        xfer_o <= ~x;
    endtask
    // one instruction end pulse
    task automatic fin();
        @(posedge clk_sys_i);
        insn_end_o <= 1'b1;
        @(posedge clk_sys_i);
        insn_end_o <= 1'b0;
    endtask
endmodule // pbk_cpu_model
`default_nettype wire

//--- sim/test_pbk_break_unit.sv
// self-checking bench for the program break unit
`timescale 1ns/1ps
`default_nettype none
module test_pbk_break_unit
    import pbk_pkg::*;
;
    logic clk_sys_i = 1'b0; // system clock
    logic rst_n_i = 1'b0; // reset, low
    logic [7:0] ra = 8'h00; // register address
    logic [31:0] wd = 32'h00000000; // write data
    logic wr = 1'b0; // write strobe
    logic rd = 1'b0; // read strobe
    logic ce = 1'b1; // clock enable
    logic [31:0] rdata; // read data
    logic bv, bx, ie, birq, bf, bd, irq, stp; // bus and outputs
    logic [23:0] ba_bus; // bus address
    logic [1:0] bk; // bus kind
    int fails = 0; // mismatches
    int n_checks = 0; // comparisons
    int npulse = 0; // break pulses seen
    int cycles = 0; // timeout counter
    logic [23:0] ba; // break address
    logic [31:0] d; // random word
    int m; // masked bit count
    always #5 clk_sys_i = ~clk_sys_i;
    pbk_break_unit uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
        .ce_i(ce), .reg_addr_i(ra), .reg_wdata_i(wd), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_valid_i(bv),
        .bus_addr_i(ba_bus), .bus_kind_i(bk), .bus_xfer_ctl_i(bx),
        .insn_end_i(ie), .break_irq_o(birq), .break_fetch_o(bf),
        .break_data_o(bd), .irq_o(irq), .mod_stop_o(stp));
    pbk_cpu_model cpu (.clk_sys_i(clk_sys_i), .valid_o(bv),
        .addr_o(ba_bus), .kind_o(bk), .xfer_o(bx), .insn_end_o(ie));
    // count one-cycle break pulses away from the edge
    always @(negedge clk_sys_i)
        if (bf === 1'b1 || bd === 1'b1)
            npulse++;
    // hang guard
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %0t word %h want %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %0t bit %b want %b", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        ra <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 chk32(rdata, e);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    // bus cycle then instruction end; data breaks wait for the end
    task automatic hit(input logic [23:0] a, input logic [1:0] k,
                       input logic x, input logic e);
        int n0;
        n0 = npulse;
        cpu.cyc(a, k, x);
        repeat (2) @(posedge clk_sys_i);
        chk1(npulse != n0, (k == KIND_FETCH) ? e : 1'b0);
        cpu.fin();
        repeat (3) @(posedge clk_sys_i);
        chk1(npulse == n0 + 1, e);
    endtask
    function automatic int mbits(input int c);
        return (c <= 4) ? c : (c - 4) * 4 + 4;
    endfunction
    function automatic logic cmatch(input int c, input int k);
        return (c == 0) ? (k == 0) : (k != 0 && ((c >> (k - 1)) & 1));
    endfunction
    initial
    begin
        void'($urandom(32'h6314));
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        #1 chk1(stp, RST_MOD_STOP);
        wreg(OFS_ADDR_A, 32'h00ABCDEF);
        rreg(OFS_ADDR_A, 32'h00000000);
        wreg(OFS_MOD_STOP, 32'h00000000);
        settle();
        chk1(stp, 1'b0);
        rreg(OFS_ADDR_A, {8'h00, RST_BRK_ADDR});
        rreg(OFS_CTRL_B, {24'h000000, RST_CTRL});
        for (int i = 0; i < 2; i++)
        begin
            d = $urandom;
            wreg(i ? OFS_ADDR_B : OFS_ADDR_A, d);
            rreg(i ? OFS_ADDR_B : OFS_ADDR_A, {8'h00, d[23:0]});
        end
        rreg(8'h1C, 32'h00000000);
        // a write while the enable is low must be lost
        @(posedge clk_sys_i);
        ce <= 1'b0;
        wreg(OFS_ADDR_B, 32'h00123456);
        ce <= 1'b1;
        rreg(OFS_ADDR_B, {8'h00, d[23:0]});
        for (int c = 0; c < 8; c++)
        begin
            ba = 24'($urandom);
            m = mbits(c);
            wreg(OFS_ADDR_A, {8'hFF, ba});
            wreg(OFS_CTRL_A, {24'h0, 2'b00, 3'(c), COND_FETCH, 1'b1});
            hit(ba ^ ((24'h000001 << m) - 24'h000001), KIND_FETCH,
                1'b0, 1'b1);
            hit(ba ^ (24'h000001 << m), KIND_FETCH, 1'b0, 1'b0);
        end
        rreg(OFS_IRQ_STAT, 32'h00000001);
        chk1(irq, 1'b0);
        wreg(OFS_IRQ_MASK, 32'h00000003);
        settle();
        chk1(irq, 1'b1);
        wreg(OFS_IRQ_STAT, 32'h00000001);
        settle();
        chk1(irq, 1'b0);
        rreg(OFS_CTRL_A, 32'h000000B9);
        wreg(OFS_CTRL_A, 32'h00000000);
        rreg(OFS_CTRL_A, 32'h00000000);
        ba = 24'($urandom);
        wreg(OFS_ADDR_B, {8'h00, ba});
        for (int c = 0; c < 4; c++)
            for (int k = 0; k < 3; k++)
            begin
                wreg(OFS_CTRL_B, {24'h0, 5'h00, 2'(c), 1'b1});
                hit(ba, 2'(k), 1'b0, cmatch(c, k));
            end
        wreg(OFS_CTRL_B, 32'h00000003);
        hit(ba, KIND_READ, 1'b1, 1'b0);
        wreg(OFS_CTRL_B, 32'h00000043);
        hit(ba, KIND_READ, 1'b1, 1'b1);
        wreg(OFS_MOD_STOP, 32'h00000001);
        hit(ba, KIND_READ, 1'b0, 1'b0);
        wreg(OFS_MOD_STOP, 32'h00000000);
        settle();
        chk1(birq, 1'b1);
        wreg(OFS_CTRL_B, 32'h00000000);
        settle();
        chk1(birq, 1'b0);
        rreg(OFS_CTRL_B, 32'h00000080);
        wreg(OFS_CTRL_B, 32'h00000000);
        rreg(OFS_CTRL_B, 32'h00000000);
        close_out();
    end
endmodule // test_pbk_break_unit
`default_nettype wire
